// ==== rtl/angle_gen_pkg.sv ====
package angle_gen_pkg;

	// Clock and derived time bases
	localparam longint CLK_HZ = 25_000_000;
	localparam int CYCLES_PER_US = int'(CLK_HZ / 1_000_000);
	localparam int ACCEPT_DELAY_MAX_US = 1000;
	localparam int ACCEPT_DELAY_MAX_CYC = ACCEPT_DELAY_MAX_US * CYCLES_PER_US;

	// Profile, role and bus codes
	localparam logic [1:0] PROF_FOUR = 2'h0;
	localparam logic [1:0] PROF_ELEC = 2'h1;
	localparam logic [1:0] PROF_TWO = 2'h2;
	localparam logic ROLE_SLAVE = 1'h0;
	localparam logic ROLE_MASTER = 1'h1;
	localparam logic [7:0] BUS_LINE0 = 8'h00;
	localparam logic [7:0] BUS_LINE1 = 8'h01;
	localparam logic [7:0] BUS_NONE = 8'hFF;

	// Speed limits in command units (0.001 rpm, 0.0005 rpm for two-stroke)
	localparam longint UNITS_PER_RPM = 1000;
	localparam longint UNITS_PER_RPM_TWO = 2000;
	localparam longint MAX_RPM_FOUR = 60000;
	localparam longint MAX_RPM_TWO = 30000;
	localparam longint MAX_RPM_ELEC = 30000;
	localparam logic signed [31:0] SPD_LIM_FOUR =
		32'(MAX_RPM_FOUR * UNITS_PER_RPM);
	localparam logic signed [31:0] SPD_LIM_TWO =
		32'(MAX_RPM_TWO * UNITS_PER_RPM_TWO);
	localparam logic signed [31:0] SPD_LIM_ELEC =
		32'(MAX_RPM_ELEC * UNITS_PER_RPM);

	// Angle is 1/65536 of a cycle; remainder scaled by 2^SPD_SHIFT
	localparam int SPD_SHIFT = 5;
	localparam longint ANGLE_STEPS = 65536;
	localparam longint REV_TICKS = 60 * CLK_HZ * UNITS_PER_RPM;
	localparam logic signed [35:0] STEP_ELEC =
		36'(REV_TICKS * (1 << SPD_SHIFT) / ANGLE_STEPS);
	localparam logic signed [35:0] STEP_FOUR = 36'(2 * REV_TICKS *
		(1 << SPD_SHIFT) / ANGLE_STEPS);
	localparam logic signed [35:0] STEP_TWO = 36'(60 * CLK_HZ *
		UNITS_PER_RPM_TWO * (1 << SPD_SHIFT) / ANGLE_STEPS);
	localparam int ADV_ITER = 3;
	localparam logic [15:0] ANGLE_LSB = 16'h0001;
	localparam int AC_BIT = 2;
	localparam logic [15:0] AC_STEP = 16'h0004;

	// Secondary phase
	localparam logic signed [17:0] PHASE_FULL = 18'sh10000;
	localparam logic [9:0] SLEW_MAX = 10'd1000;
	localparam logic [35:0] SLEW_LIMIT = 36'(360 * CLK_HZ);
	localparam int SLEW_SCALE_SH = 16;
	localparam logic [9:0] DELAY_MAX_US = 10'd1000;

	// Register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_START = 4'h1;
	localparam logic [3:0] REG_SPEED = 4'h2;
	localparam logic [3:0] REG_TARGET = 4'h3;
	localparam logic [3:0] REG_DELAY = 4'h4;
	localparam logic [3:0] REG_PHASE = 4'h5;
	localparam logic [3:0] REG_SLEW = 4'h6;
	localparam logic [3:0] REG_ANGLE = 4'h7;
	localparam logic [3:0] REG_SECOND = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'h9;
	localparam int CTRL_INIT_BIT = 4;

	typedef struct packed {
		logic [7:0] bus_sel;
		logic [2:0] rsvd;
		logic init;
		logic adapt;
		logic role;
		logic [1:0] profile;
	} ctrl_t;

	typedef struct packed {
		logic [15:0] angle;
		logic signed [35:0] rem;
	} adv_t;

	typedef enum logic {
		CAP_IDLE = 1'b0,
		CAP_WAIT = 1'b1
	} cap_state_t;

endpackage

// ==== rtl/engine_angle_generator.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Profile code selects four-stroke, electric, two-stroke
// - Role slave/master; bus line 0, 1, none
// - Start angle spans full profile cycle
// - Initialization restarts rotation at start angle
// - Four-stroke speed +-60000 rpm, 0.001 step
// - Two-stroke speed +-30000 rpm, 0.0005 step
// - Negative speed turns angle backwards
// - Crank angle reported over profile cycle
// - Electric speed +-30000 rpm, 0.001 step
// - Target angle used only in adaptive master, electric profile
// - Targets taken after programmable trigger delay
// - Secondary angle offset by programmable phase
// - Phase changes slew at rate; zero immediate
// - Rotor angle reported 0 to 360
// - Secondary angle reported 0 to 360
// - Master drives sync line; slave follows it
module engine_angle_generator
	import angle_gen_pkg::*;
#(
	parameter int DELAY_MAX_CYC = ACCEPT_DELAY_MAX_CYC
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic [1:0] sync_in,
	output logic [1:0] sync_out,
	output logic [1:0] sync_oe_out,
	input wire logic trigger_in,
	output logic [15:0] angle_out,
	output logic [15:0] secondary_out
);

	function automatic logic signed [31:0] clamp_speed(
		input logic [1:0] prof, input logic signed [31:0] raw);
		logic signed [31:0] lim;
		unique case (prof)
			PROF_FOUR: lim = SPD_LIM_FOUR;
			PROF_TWO: lim = SPD_LIM_TWO;
			default: lim = SPD_LIM_ELEC;
		endcase
		if (raw > lim) begin
			return lim;
		end else if (raw < -lim) begin
			return -lim;
		end
		return raw;
	endfunction

	function automatic logic signed [35:0] step_of(input logic [1:0] prof);
		unique case (prof)
			PROF_FOUR: return STEP_FOUR;
			PROF_TWO: return STEP_TWO;
			default: return STEP_ELEC;
		endcase
	endfunction

	function automatic logic is_master(input ctrl_t c);
		return c.role == ROLE_MASTER;
	endfunction

	function automatic adv_t advance(input logic [15:0] a,
		input logic signed [35:0] r, input logic signed [31:0] spd,
		input logic signed [35:0] st);
		adv_t res;
		res.angle = a;
		res.rem = r + (36'(spd) <<< SPD_SHIFT);
		for (int i = 0; i < ADV_ITER; i++) begin
			if (res.rem >= st) begin
				res.rem = res.rem - st;
				res.angle = res.angle + ANGLE_LSB;
			end else if (res.rem < 0) begin
				res.rem = res.rem + st;
				res.angle = res.angle - ANGLE_LSB;
			end
		end
		return res;
	endfunction

	ctrl_t ctrl_r;
	logic [15:0] start_r;
	logic signed [31:0] speed_cmd_r;
	logic [15:0] target_r;
	logic [9:0] delay_us_r;
	logic signed [17:0] phase_tgt_r;
	logic [9:0] slew_r;
	logic init_r;
	logic [1:0] sync_m_r;
	logic [1:0] sync_s_r;
	logic [1:0] sync_d_r;
	logic trig_m_r;
	logic trig_s_r;
	logic trig_d_r;
	cap_state_t cap_state_r;
	logic [15:0] cap_cnt_r;
	logic cap_fire_r;
	logic signed [31:0] speed_eff_r;
	logic [15:0] angle_r;
	logic signed [35:0] rem_r;
	logic signed [17:0] phase_now_r;
	logic [35:0] slew_acc_r;
	logic ac_r;

	logic cfg_err;
	logic adaptive;
	logic line_sel;
	logic line_used;
	logic slave_edge;
	logic trig_rise;
	logic signed [31:0] speed_lim;
	adv_t adv_nxt;
	logic [15:0] delay_load;
	logic [15:0] secondary_nxt;

	always_comb begin
		// Illegal profile or bus code, or no line in slave role, stops the generator
		cfg_err = (ctrl_r.profile != PROF_FOUR) &&
			(ctrl_r.profile != PROF_ELEC) && (ctrl_r.profile != PROF_TWO);
		if ((ctrl_r.bus_sel != BUS_LINE0) && (ctrl_r.bus_sel != BUS_LINE1)
			&& !((ctrl_r.bus_sel == BUS_NONE) &&
			is_master(ctrl_r))) begin
			cfg_err = 1'b1;
		end
		adaptive = is_master(ctrl_r) && ctrl_r.adapt;
		line_sel = ctrl_r.bus_sel[0];
		line_used = (ctrl_r.bus_sel != BUS_NONE);
		slave_edge = sync_s_r[line_sel] ^ sync_d_r[line_sel];
		trig_rise = trig_s_r && !trig_d_r;
		speed_lim = clamp_speed(ctrl_r.profile, speed_cmd_r);
		adv_nxt = advance(angle_r, rem_r, speed_eff_r,
			step_of(ctrl_r.profile));
		delay_load = 16'(32'(delay_us_r) * CYCLES_PER_US);
		if (32'(delay_load) > DELAY_MAX_CYC) begin
			delay_load = 16'(DELAY_MAX_CYC);
		end
		secondary_nxt = angle_r + phase_now_r[15:0];
	end

	// Register writes
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_r <= '0;
			start_r <= '0;
			speed_cmd_r <= '0;
			target_r <= '0;
			delay_us_r <= '0;
			phase_tgt_r <= '0;
			slew_r <= '0;
			init_r <= 1'b0;
		end else begin
			init_r <= wr_in && (addr_in == REG_CTRL) &&
				wdata_in[CTRL_INIT_BIT];
			if (wr_in) begin
				unique case (addr_in)
					REG_CTRL: begin
						ctrl_r <= ctrl_t'(wdata_in[$bits(ctrl_t)-1:0]);
						ctrl_r.init <= 1'b0;
						ctrl_r.rsvd <= '0;
					end
					REG_START: start_r <= wdata_in[15:0];
					REG_SPEED: speed_cmd_r <= wdata_in;
					REG_TARGET: target_r <= wdata_in[15:0];
					REG_DELAY: begin
						delay_us_r <= (wdata_in[9:0] > DELAY_MAX_US) ?
							DELAY_MAX_US : wdata_in[9:0];
					end
					REG_PHASE: begin
						if ($signed(wdata_in[17:0]) > PHASE_FULL ||
							$signed(wdata_in[17:0]) < -PHASE_FULL) begin
							phase_tgt_r <= wdata_in[17] ? -PHASE_FULL :
								PHASE_FULL;
						end else begin
							phase_tgt_r <= $signed(wdata_in[17:0]);
						end
					end
					REG_SLEW: begin
						slew_r <= (wdata_in[9:0] > SLEW_MAX) ?
							SLEW_MAX : wdata_in[9:0];
					end
					default: ;
				endcase
			end
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_out <= '0;
		end else if (rd_in) begin
			unique case (addr_in)
				REG_CTRL: rdata_out <= 32'(ctrl_r);
				REG_START: rdata_out <= 32'(start_r);
				REG_SPEED: rdata_out <= speed_cmd_r;
				REG_TARGET: rdata_out <= 32'(target_r);
				REG_DELAY: rdata_out <= 32'(delay_us_r);
				REG_PHASE: rdata_out <= 32'(phase_tgt_r);
				REG_SLEW: rdata_out <= 32'(slew_r);
				REG_ANGLE: rdata_out <= 32'(angle_r);
				REG_SECOND: rdata_out <= 32'(secondary_out);
				REG_STATUS: rdata_out <= {28'h0000000,
					(phase_now_r != phase_tgt_r),
					(cap_state_r == CAP_WAIT), !cfg_err, cfg_err};
				default: rdata_out <= '0;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end

	// Pin synchronisers
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			sync_m_r <= '0;
			sync_s_r <= '0;
			sync_d_r <= '0;
			trig_m_r <= 1'b0;
			trig_s_r <= 1'b0;
			trig_d_r <= 1'b0;
		end else begin
			sync_m_r <= sync_in;
			sync_s_r <= sync_m_r;
			sync_d_r <= sync_s_r;
			trig_m_r <= trigger_in;
			trig_s_r <= trig_m_r;
			trig_d_r <= trig_s_r;
		end
	end

	// Delayed take-over of target speed, and of target angle in electric profile
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			cap_state_r <= CAP_IDLE;
			cap_cnt_r <= '0;
			cap_fire_r <= 1'b0;
		end else begin
			cap_fire_r <= 1'b0;
			unique case (cap_state_r)
				CAP_IDLE: begin
					if (adaptive && trig_rise) begin
						cap_cnt_r <= delay_load;
						cap_state_r <= CAP_WAIT;
					end
				end
				CAP_WAIT: begin
					if (!adaptive) begin
						cap_state_r <= CAP_IDLE;
					end else if (cap_cnt_r == '0) begin
						cap_fire_r <= 1'b1;
						cap_state_r <= CAP_IDLE;
					end else begin
						cap_cnt_r <= cap_cnt_r - 16'h0001;
					end
				end
			endcase
		end
	end

	// Effective speed: immediate unless adaptive master
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			speed_eff_r <= '0;
		end else if (!adaptive || cap_fire_r) begin
			speed_eff_r <= speed_lim;
		end
	end

	// Angle generation
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			angle_r <= '0;
			rem_r <= '0;
		end else if (init_r) begin
			angle_r <= start_r;
			rem_r <= '0;
		end else if (cfg_err) begin
			rem_r <= rem_r;
		end else if (cap_fire_r && ctrl_r.profile == PROF_ELEC) begin
			angle_r <= target_r;
			rem_r <= '0;
		end else if (!is_master(ctrl_r)) begin
			// Slave steps a fixed amount per angle-clock edge
			// Direction follows the sign of the commanded speed
			if (slave_edge) begin
				angle_r <= (speed_eff_r < 0) ? angle_r - AC_STEP :
					angle_r + AC_STEP;
			end
		end else begin
			angle_r <= adv_nxt.angle;
			rem_r <= adv_nxt.rem;
		end
	end

	// Secondary phase slewing
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			phase_now_r <= '0;
			slew_acc_r <= '0;
		end else if (slew_r == '0) begin
			phase_now_r <= phase_tgt_r;
			slew_acc_r <= '0;
		end else if (phase_now_r == phase_tgt_r) begin
			slew_acc_r <= '0;
		end else if (slew_acc_r >= SLEW_LIMIT) begin
			slew_acc_r <= slew_acc_r - SLEW_LIMIT;
			phase_now_r <= (phase_now_r < phase_tgt_r) ?
				phase_now_r + 18'sh00001 : phase_now_r - 18'sh00001;
		end else begin
			slew_acc_r <= slew_acc_r + (36'(slew_r) << SLEW_SCALE_SH);
		end
	end

	// Angle clock and outputs
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ac_r <= 1'b0;
			sync_out <= '0;
			sync_oe_out <= '0;
			angle_out <= '0;
			secondary_out <= '0;
		end else begin
			// Angle clock is one angle bit, two cycles behind
			ac_r <= angle_r[AC_BIT];
			sync_out <= {2{ac_r}};
			sync_oe_out <= '0;
			if (is_master(ctrl_r) && line_used && !cfg_err) begin
				sync_oe_out[line_sel] <= 1'b1;
			end
			angle_out <= angle_r;
			secondary_out <= secondary_nxt;
		end
	end

endmodule

// ==== test/engine_angle_generator_props.sv ====
`timescale 1ns/1ps
module angle_props
	import angle_gen_pkg::*;
#(parameter int DELAY_MAX_CYC = 50) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic [1:0] sync_out,
	input wire logic [1:0] sync_oe_out,
	input wire logic [15:0] angle_out,
	input wire logic [15:0] secondary_out
);
	ctrl_t c;
	logic [15:0] st, ph;
	logic signed [31:0] sp;
	logic [9:0] sl;
	logic [2:0] age;
	logic leg, calm;
	logic [1:0] oe;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);
	// Shadow of the written configuration
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			c <= '0;
			st <= '0;
			ph <= '0;
			sp <= '0;
			sl <= '0;
			age <= '0;
		end else begin
			age <= wr_in ? 3'h0 : age + 3'(age != 3'h7);
			if (wr_in && addr_in == REG_CTRL)
				c <= ctrl_t'(wdata_in[15:0]);
			if (wr_in && addr_in == REG_START)
				st <= wdata_in[15:0];
			if (wr_in && addr_in == REG_PHASE)
				ph <= wdata_in[15:0];
			if (wr_in && addr_in == REG_SPEED)
				sp <= wdata_in;
			if (wr_in && addr_in == REG_SLEW)
				sl <= wdata_in[9:0];
		end
	end
	assign leg = c.profile != 2'h3 &&
		(c.bus_sel < 8'h02 || c.role && c.bus_sel == BUS_NONE);
	assign calm = age == 3'h7 && c.role && !c.adapt && leg;
	assign oe = (leg && c.role && c.bus_sel < 8'h02) ?
		2'h1 << c.bus_sel[0] : 2'h0;
	AST_RD_IDLE: assert property (
		!$past(rd_in) |-> rdata_out == 32'h0) else $error("stray read data");
	AST_INIT_START: assert property (
		wr_in && addr_in == REG_CTRL && wdata_in[4] && wdata_in[2] &&
		wdata_in[1:0] != 2'h3 && wdata_in[15:8] inside {8'h00, 8'h01, 8'hFF}
		|-> ##3 angle_out == st) else $error("init angle wrong");
	AST_SYNC_OE: assert property (
		age == 3'h7 |-> sync_oe_out == oe) else $error("sync drive wrong");
	AST_SYNC_CLK: assert property (
		sync_out == {2{$past(angle_out[2])}}) else $error("angle clock wrong");
	AST_BOTH_OE: assert property (
		sync_oe_out != 2'h3) else $error("two lines driven");
	AST_HOLD: assert property (
		calm && sp == 0 |=> $stable(angle_out)) else $error("angle drifts");
	AST_FWD: assert property (
		calm && sp > 0 |=> 16'(angle_out - $past(angle_out)) < 16'h0004)
		else $error("forward step wrong");
	AST_REV: assert property (
		calm && sp < 0 |=> 16'($past(angle_out) - angle_out) < 16'h0004)
		else $error("reverse step wrong");
	AST_PHASE: assert property (
		calm && sp == 0 && sl == 10'h0 |-> secondary_out ==
		16'(angle_out + ph)) else $error("phase offset wrong");
	AST_SLEW: assert property (
		calm && sp == 0 |=>
		16'(secondary_out - $past(secondary_out) + 16'h1) < 16'h0003)
		else $error("secondary jumps");
endmodule
bind engine_angle_generator angle_props #(.DELAY_MAX_CYC(DELAY_MAX_CYC))
	u_props (.mclk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
	.rdata_out, .sync_out, .sync_oe_out, .angle_out, .secondary_out);

// ==== test/sync_line_model.sv ====
`timescale 1ns/1ps
module sync_line_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] en_in,
	output logic [1:0] line_out
);
	logic [1:0] div_r;
	// Far master clocks a line only while enabled; a free line wanders
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			div_r <= 2'h0;
			line_out <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
			for (int i = 0; i < 2; i++)
				if (!en_in[i] || div_r == 2'h0)
					line_out[i] <= !line_out[i];
		end
	end
endmodule

// ==== test/engine_angle_generator_test.sv ====
`timescale 1ns/1ps
module engine_angle_generator_test;
	import angle_gen_pkg::*;
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic trigger_in = 1'b0;
	logic [1:0] en = 2'h0;
	logic [31:0] rdata_out, a0, a1, e;
	logic [1:0] sync_out, sync_oe_out, line, sync_w;
	logic [15:0] angle_out, secondary_out, v;
	logic [3:0] ix [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hC};
	int bad_count = 0;
	int total_checks = 0;
	int ex;
	always #20 mclk_in = ~mclk_in;
	assign sync_w = sync_oe_out & sync_out | ~sync_oe_out & line;
	engine_angle_generator #(.DELAY_MAX_CYC(50)) u_dut (.mclk_in,
		.reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.sync_in(sync_w), .sync_out, .sync_oe_out, .trigger_in,
		.angle_out, .secondary_out);
	sync_line_model u_far (.clk_in(mclk_in), .rst_in(reset_in),
		.en_in(en), .line_out(line));
	task automatic wrap_up();
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic note(input logic ok, input logic [31:0] g, e);
		total_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	function automatic logic near(logic [15:0] g, e, int t);
		return !$isunknown(g) && 16'(g - e + 16'(t)) <= 16'(2 * t);
	endfunction
	function automatic logic [31:0] model_rd(logic [3:0] a, logic [31:0] d);
		case (a)
			REG_START, REG_TARGET: return {16'h0, d[15:0]};
			REG_DELAY, REG_SLEW: return 32'(d[9:0] > 10'h3E8 ? 10'h3E8 : d[9:0]);
			REG_SPEED: return d;
			default: return 32'h0;
		endcase
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	initial begin
		tick(100000);
		bad_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(90955));
		tick(8);
		reset_in <= 1'b0;
		foreach (ix[i]) begin
			a0 = ix[i] == REG_DELAY ? 32'h3FF : $urandom % 32'h100000;
			wr(ix[i], a0);
			rd(ix[i], a1);
			e = model_rd(ix[i], a0);
			note(a1 === e, a1, e);
		end
		wr(REG_CTRL, 32'hFF15);
		rd(REG_CTRL, a1);
		note(a1 === 32'hFF05, a1, 32'hFF05);
		for (int p = 0; p < 3; p++)
			for (int s = -1; s < 2; s += 2) begin
				v = {s > 0 ? 8'hFF : 8'h00, 8'($urandom)};
				wr(REG_START, {16'h0, v});
				wr(REG_SPEED, 32'(s * (p == 1 ? 30000000 : 60000000)));
				wr(REG_CTRL, 32'hFF14 | p);
				rd(REG_ANGLE, a0);
				tick(998);
				rd(REG_ANGLE, a1);
				ex = s * (p == 1 ? 30 : 60) * 65536 / (p == 1 ? 1500 : 3000);
				e = 32'(a0[15:0] + 16'(ex));
				note(near(a1[15:0], e[15:0], 1), a1, e);
			end
		for (int b = 0; b < 3; b++) begin
			wr(REG_CTRL, 32'h0014 | (b == 2 ? 32'hFF00 : b << 8));
			tick(4);
			e = b == 2 ? 0 : b + 1;
			note(sync_oe_out === e[1:0], sync_oe_out, e);
		end
		wr(REG_CTRL, 32'hFF10);
		rd(REG_ANGLE, a0);
		tick(50);
		rd(REG_ANGLE, a1);
		note(a1 === a0 && sync_oe_out === 2'h0, a1, a0);
		rd(REG_STATUS, a1);
		note(a1 === 32'h1, a1, 32'h1);
		en <= 2'h2;
		for (int s = -1; s < 2; s += 2) begin
			wr(REG_SPEED, 32'(s));
			wr(REG_CTRL, 32'h0110);
			tick(10);
			rd(REG_ANGLE, a0);
			tick(198);
			rd(REG_ANGLE, a1);
			e = 32'(a0[15:0] + 16'(s * 200));
			note(near(a1[15:0], e[15:0], 4), a1, e);
		end
		en <= 2'h0;
		wr(REG_SPEED, 32'h0);
		wr(REG_SLEW, 32'h0);
		wr(REG_CTRL, 32'hFF15);
		for (int s = -1; s < 2; s += 2) begin
			v = 16'($urandom);
			wr(REG_PHASE, 32'(s * int'(v)));
			tick(4);
			rd(REG_ANGLE, a0);
			rd(REG_SECOND, a1);
			e = 32'(a0[15:0] + 16'(s * int'(v)));
			note(near(a1[15:0], e[15:0], 0), a1, e);
			note(secondary_out === a1[15:0], secondary_out, a1);
		end
		wr(REG_SLEW, 32'h3E8);
		wr(REG_PHASE, 32'(int'(v) - 8));
		tick(100);
		rd(REG_SECOND, a1);
		note(near(a1[15:0], e[15:0], 1), a1, e);
		tick(1200);
		rd(REG_SECOND, a1);
		e = e - 32'h8;
		note(near(a1[15:0], e[15:0], 0), a1, e);
		for (int k = 0; k < 2; k++) begin
			v = 16'($urandom);
			wr(REG_TARGET, {16'h0, v});
			wr(REG_DELAY, 32'h4);
			wr(REG_CTRL, k ? 32'hFF1D : 32'hFF15);
			tick(5);
			rd(REG_ANGLE, a0);
			trigger_in <= 1'b1;
			tick(3);
			trigger_in <= 1'b0;
			tick(30);
			rd(REG_ANGLE, a1);
			note(a1 === a0, a1, a0);
			tick(60);
			rd(REG_ANGLE, a1);
			e = k ? {16'h0, v} : a0;
			note(a1 === e, a1, e);
			note(angle_out === e[15:0], angle_out, e);
		end
		wrap_up();
	end
endmodule
